// File: design/socket_system_control_fields.sv
// System control field bank for a dual-socket card controller, Avalon-MM slave
`timescale 1ns/1ps
module socket_system_control_fields #(
    parameter int RISE_WAIT_CYCLES = sysctl_pkg::RISE_WAIT_CYC,
    parameter int FALL_WAIT_CYCLES = sysctl_pkg::FALL_WAIT_CYC
) (
    // Clock and global reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Bus reset pin and PME context
    input wire logic bus_reset_n_in,
    input wire logic pme_enable_in,
    // Avalon-MM slave
    input wire logic [sysctl_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic [1:0] avs_response_out,
    output logic avs_waitrequest_out,
    // Socket events from card logic
    input wire logic [sysctl_pkg::SOCKETS-1:0] cardbus_present_in,
    input wire logic [sysctl_pkg::SOCKETS-1:0] card_access_in,
    input wire logic [sysctl_pkg::SOCKETS-1:0] probe_start_in,
    input wire logic [sysctl_pkg::SOCKETS-1:0] probe_done_in,
    // Power switch sequencing
    input wire logic power_req_in,
    input wire logic power_up_in,
    input wire logic stream_done_in,
    // Spare CardBus pins, open drain
    output logic [sysctl_pkg::SOCKETS-1:0] spare_pin_out,
    output logic [sysctl_pkg::SOCKETS-1:0] spare_pin_oe_out,
    // Control and interrupt
    output sysctl_pkg::ctrl_t ctrl_out,
    output logic irq_out
);
    import sysctl_pkg::*;

    // Synchronised pins
    logic bus_rst_sync_n;
    logic [SOCKETS-1:0] present_sync;

    sync2 #(.W(1), .RESET_VAL(1'b1)) u_bus_rst_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .d_in(bus_reset_n_in),
        .q_out(bus_rst_sync_n)
    );

    sync2 #(.W(SOCKETS), .RESET_VAL('0)) u_present_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .d_in(cardbus_present_in),
        .q_out(present_sync)
    );

    // Context bits only follow the bus reset while PME is off
    wire context_clear = !bus_rst_sync_n && !pme_enable_in;

    // Bus handshake: one wait cycle, answer at the second edge
    logic ack;
    wire req = avs_read_in | avs_write_in;
    // Read-clear acts on the capture edge, so an access after capture is never lost
    wire rd_grab = avs_read_in & ~ack;
    wire wr_take = avs_write_in & ack;
    assign avs_waitrequest_out = req & ~ack;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    // Address decode
    wire hit_fn0 = avs_address_in == SYSCTL_FN0_ADDR;
    wire hit_fn1 = avs_address_in == SYSCTL_FN1_ADDR;
    wire hit_stat = avs_address_in == IRQ_STATUS_ADDR;
    wire hit_clr = avs_address_in == IRQ_CLEAR_ADDR;
    wire hit_en = avs_address_in == IRQ_ENABLE_ADDR;
    wire hit_any = hit_fn0 | hit_fn1 | hit_stat | hit_clr | hit_en;
    wire [SOCKETS-1:0] hit_fn = {hit_fn1, hit_fn0};
    wire [3:0] be = avs_byteenable_in;
    wire [31:0] wd = avs_writedata_in;
    wire wr_shared = wr_take & (hit_fn0 | hit_fn1);
    // Global bits are only written through function 0
    wire wr_global = wr_take & hit_fn0;

    // Shared and global fields, global reset only
    logic spare_drive;
    logic [4:0] spare_bits;
    logic burst_card;
    logic burst_host;
    logic low_power;
    logic id_lock;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            spare_drive <= RST_SPARE_DRIVE;
            spare_bits <= RST_SPARE_BITS;
            burst_card <= RST_BURST_CARD;
            burst_host <= RST_BURST_HOST;
            low_power <= RST_LOW_POWER;
            id_lock <= RST_ID_LOCK;
        end else begin
            if (wr_shared && be[2]) begin
                spare_drive <= wd[BIT_SPARE_DRIVE];
                spare_bits <= wd[BIT_SPARE_HI:BIT_SPARE_LO];
            end
            if (wr_global && be[1]) begin
                burst_card <= wd[BIT_BURST_CARD];
                burst_host <= wd[BIT_BURST_HOST];
            end
            if (wr_global && be[0]) begin
                low_power <= wd[BIT_LOW_POWER];
                id_lock <= wd[BIT_ID_LOCK];
            end
        end
    end

    // Per-socket fields, plus the shared power status bits
    logic [SOCKETS-1:0] guard_disable;
    logic [SOCKETS-1:0] access_seen;
    logic [SOCKETS-1:0] probe_busy;
    logic [SOCKETS-1:0] probe_finish;
    logic serial_busy;
    logic rise_wait;
    logic fall_wait;
    logic [31:0] fn_word [SOCKETS];

    genvar s;
    generate
        for (s = 0; s < SOCKETS; s++) begin : g_sock
            wire seen_read = rd_grab & hit_fn[s];

            always_ff @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    guard_disable[s] <= 1'b0;
                    access_seen[s] <= 1'b0;
                end else begin
                    if (wr_take && hit_fn[s] && be[2]) begin
                        guard_disable[s] <= wd[BIT_GUARD_DISABLE];
                    end
                    // A new access in the read cycle keeps the flag set
                    access_seen[s] <= (access_seen[s] & ~seen_read) | card_access_in[s];
                end
            end

            always_ff @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    probe_busy[s] <= 1'b0;
                end else if (context_clear) begin
                    probe_busy[s] <= 1'b0;
                end else if (probe_start_in[s]) begin
                    probe_busy[s] <= 1'b1;
                end else if (probe_done_in[s]) begin
                    probe_busy[s] <= 1'b0;
                end
            end

            assign probe_finish[s] = probe_done_in[s] & probe_busy[s];

            always_comb begin
                fn_word[s] = 32'h0000_0000;
                fn_word[s][BIT_SPARE_DRIVE] = spare_drive;
                fn_word[s][BIT_GUARD_DISABLE] = guard_disable[s];
                fn_word[s][BIT_SPARE_HI:BIT_SPARE_LO] = spare_bits;
                fn_word[s][BIT_BURST_CARD] = burst_card;
                fn_word[s][BIT_BURST_HOST] = burst_host;
                fn_word[s][BIT_ACCESS_SEEN] = access_seen[s];
                fn_word[s][BIT_READS_ONE] = 1'b1;
                fn_word[s][BIT_SERIAL_BUSY] = serial_busy;
                fn_word[s][BIT_RISE_WAIT] = rise_wait;
                fn_word[s][BIT_FALL_WAIT] = fall_wait;
                fn_word[s][BIT_PROBE_BUSY] = probe_busy[s];
                fn_word[s][BIT_READS_ZERO] = 1'b0;
                fn_word[s][BIT_LOW_POWER] = low_power;
                fn_word[s][BIT_ID_LOCK] = id_lock;
            end

            // Spare pins only ever sink; a float is simply no enable
            assign spare_pin_out[s] = 1'b0;
            assign spare_pin_oe_out[s] = spare_drive & present_sync[s];
        end
    endgenerate

    // Power switch sequencing
    logic dir_up;
    logic delay_busy;
    logic delay_done;
    // A request while a stream is still running is dropped
    wire power_take = power_req_in & ~serial_busy;
    wire delay_start = stream_done_in & serial_busy & ~delay_busy;

    power_delay_timer #(
        .RISE_CYCLES(RISE_WAIT_CYCLES),
        .FALL_CYCLES(FALL_WAIT_CYCLES),
        .CNT_W(32)
    ) u_delay (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .start_in(delay_start),
        .up_in(dir_up),
        .busy_out(delay_busy),
        .done_out(delay_done)
    );

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            serial_busy <= 1'b0;
            dir_up <= 1'b0;
        end else if (power_take) begin
            serial_busy <= 1'b1;
            dir_up <= power_up_in;
        end else if (delay_done) begin
            serial_busy <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rise_wait <= 1'b0;
            fall_wait <= 1'b0;
        end else if (context_clear) begin
            rise_wait <= 1'b0;
            fall_wait <= 1'b0;
        end else if (delay_start) begin
            rise_wait <= dir_up;
            fall_wait <= ~dir_up;
        end else if (delay_done) begin
            rise_wait <= 1'b0;
            fall_wait <= 1'b0;
        end
    end

    // Interrupt status, write-one-to-clear, enable
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    wire [IRQ_W-1:0] irq_event = {probe_finish, delay_done};
    wire [IRQ_W-1:0] irq_clr = (wr_take & hit_clr & be[0]) ? wd[IRQ_W-1:0] : '0;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_status <= '0;
            irq_enable <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_event;
            if (wr_take && hit_en && be[0]) begin
                irq_enable <= wd[IRQ_W-1:0];
            end
        end
    end

    assign irq_out = |(irq_status & irq_enable);

    // Read mux, captured in the wait cycle
    wire [31:0] rd_mux = hit_fn0 ? fn_word[0] :
                         hit_fn1 ? fn_word[1] :
                         hit_stat ? {{(32-IRQ_W){1'b0}}, irq_status} :
                         hit_en ? {{(32-IRQ_W){1'b0}}, irq_enable} : 32'h0000_0000;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h0000_0000;
            avs_response_out <= RESP_OKAY;
        end else if (req && !ack) begin
            avs_readdata_out <= avs_read_in ? rd_mux : 32'h0000_0000;
            avs_response_out <= hit_any ? RESP_OKAY : RESP_DECODE_ERR;
        end
    end

    assign ctrl_out.supply_guard_disable = guard_disable;
    assign ctrl_out.read_burst_toward_card = burst_card;
    assign ctrl_out.read_burst_toward_host = burst_host;
    assign ctrl_out.low_power_enable = low_power;
    assign ctrl_out.id_write_lock = id_lock;

    // Checks
    a_spare_pin_float: assert property (@(posedge mclk_in) disable iff (rst_in)
        !spare_drive |-> spare_pin_oe_out == '0)
        else $error("spare pins driven while drive bit clear");

    a_guard_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        (wr_take && hit_fn1 && be[2]) |=> ctrl_out.supply_guard_disable[1] == $past(wd[21]))
        else $error("socket 1 guard bit did not take write");

    a_burst_card_wr: assert property (@(posedge mclk_in) disable iff (rst_in)
        (wr_global && be[1]) |=> ctrl_out.read_burst_toward_card == $past(wd[15]))
        else $error("downstream burst enable did not take write");

    a_fn1_no_global: assert property (@(posedge mclk_in) disable iff (rst_in)
        (wr_take && hit_fn1) |=> $stable(burst_host) && $stable(id_lock))
        else $error("function 1 write changed a global bit");

    a_read_clears_seen: assert property (@(posedge mclk_in) disable iff (rst_in)
        (rd_grab && hit_fn0 && !card_access_in[0]) |=> !access_seen[0])
        else $error("activity flag not cleared by read");

    a_access_sets_seen: assert property (@(posedge mclk_in) disable iff (rst_in)
        card_access_in[1] |=> access_seen[1])
        else $error("activity flag missed an access");

    a_reads_one_bit: assert property (@(posedge mclk_in) disable iff (rst_in)
        (avs_read_in && !ack && hit_fn0) |=> avs_readdata_out[12] && avs_waitrequest_out == 1'b0)
        else $error("bit 12 not read as one");

    a_reads_zero_bit: assert property (@(posedge mclk_in) disable iff (rst_in)
        (avs_read_in && !ack && hit_fn1) |=> !avs_readdata_out[7])
        else $error("bit 7 not read as zero");

    a_busy_to_delay: assert property (@(posedge mclk_in) disable iff (rst_in)
        (power_take ##1 !delay_done [*2]) |=> serial_busy)
        else $error("stream busy dropped before delay end");

    a_rise_after_stream: assert property (@(posedge mclk_in) disable iff (rst_in)
        (delay_start && dir_up && !context_clear) |=> rise_wait && !fall_wait)
        else $error("power-up wait not set after stream");

    a_fall_after_stream: assert property (@(posedge mclk_in) disable iff (rst_in)
        (delay_start && !dir_up && !context_clear) |=> fall_wait && !rise_wait)
        else $error("power-down wait not set after stream");

    a_probe_clears: assert property (@(posedge mclk_in) disable iff (rst_in)
        (probe_done_in[0] && !probe_start_in[0]) |=> !probe_busy[0])
        else $error("probe busy stuck after finish");

    a_globals_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!bus_rst_sync_n && !wr_take) |=> $stable(burst_card) && $stable(spare_drive))
        else $error("global bit moved under bus reset");

    a_context_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
        context_clear |=> !rise_wait && !fall_wait && probe_busy == '0)
        else $error("context bits survived bus reset without PME");

    a_probe_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
        (probe_start_in[1] && !context_clear) |=> probe_busy[1])
        else $error("probe busy not set by start");

    a_lock_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        (wr_global && be[0]) |=> ctrl_out.id_write_lock == $past(wd[BIT_ID_LOCK]))
        else $error("identity lock bit did not take write");

    a_delay_end: assert property (@(posedge mclk_in) disable iff (rst_in)
        delay_done |=> !serial_busy && !rise_wait && !fall_wait)
        else $error("power status bits held past delay end");
endmodule

// File: pkg/sysctl_pkg.sv
// Constants and types for the socket system control field bank
// Operation
// - Bit 22 set (reset) drives spare CardBus pins low with card in; clear floats.
// - Per-socket bit 21: zero keeps 16-bit supply protection, one disables it.
// - Bit 15 set (default) allows downstream memory read bursts; clear forbids.
// - Bit 14 set allows upstream memory read bursts; resets to zero.
// - Per-socket bit 13 sets on any card access; a read of that socket's function register clears it.
// - Bit 12 is read-only and always reads one.
// - Bit 11 high from power change request until stream and delay finish.
// - Bit 10 sets after power-up stream sent; clears when power-up delay expires.
// - Bit 9 sets after power-down stream sent; clears when power-down delay expires.
// - Per-socket bit 8 high while card interrogation runs; clears when done.
// - Bit 7 is read-only and always reads zero.
// - Bit 6 enables loss-free power savings; global, written through function 0 only; resets to one.
// - Bit 5 one (default) locks identity registers read-only; zero allows writes.
// - Bits 22 to 11, 6 and 5 cleared by global reset only.
// - Bits 10, 9, 8 survive bus reset while PME enabled; else bus reset clears.
package sysctl_pkg;
    localparam int ADDR_W = 12;
    localparam int SOCKETS = 2;
    localparam logic [11:0] SYSCTL_FN0_ADDR = 12'h080;
    localparam logic [11:0] SYSCTL_FN1_ADDR = 12'h180;
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h200;
    localparam logic [11:0] IRQ_CLEAR_ADDR = 12'h204;
    localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h208;
    localparam int BIT_SPARE_DRIVE = 22;
    localparam int BIT_GUARD_DISABLE = 21;
    localparam int BIT_SPARE_HI = 20;
    localparam int BIT_SPARE_LO = 16;
    localparam int BIT_BURST_CARD = 15;
    localparam int BIT_BURST_HOST = 14;
    localparam int BIT_ACCESS_SEEN = 13;
    localparam int BIT_READS_ONE = 12;
    localparam int BIT_SERIAL_BUSY = 11;
    localparam int BIT_RISE_WAIT = 10;
    localparam int BIT_FALL_WAIT = 9;
    localparam int BIT_PROBE_BUSY = 8;
    localparam int BIT_READS_ZERO = 7;
    localparam int BIT_LOW_POWER = 6;
    localparam int BIT_ID_LOCK = 5;
    localparam logic RST_SPARE_DRIVE = 1'b1;
    localparam logic RST_BURST_CARD = 1'b1;
    localparam logic RST_BURST_HOST = 1'b0;
    localparam logic RST_LOW_POWER = 1'b1;
    localparam logic RST_ID_LOCK = 1'b1;
    localparam logic [4:0] RST_SPARE_BITS = 5'h00;
    localparam int IRQ_W = 3;
    localparam int IRQ_POWER_DONE = 0;
    localparam int IRQ_PROBE_DONE0 = 1;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RISE_WAIT_NS = 1000000;
    localparam int FALL_WAIT_NS = 1000000;
    localparam int RISE_WAIT_CYC = (RISE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FALL_WAIT_CYC = (FALL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECODE_ERR = 2'h3;

    typedef struct packed {
        logic [SOCKETS-1:0] supply_guard_disable;
        logic read_burst_toward_card;
        logic read_burst_toward_host;
        logic low_power_enable;
        logic id_write_lock;
    } ctrl_t;
endpackage

// File: design/sync2.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            meta <= RESET_VAL;
            q_out <= RESET_VAL;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule

// File: design/power_delay_timer.sv
// Settling delay timer after a stream reaches the power switch
`timescale 1ns/1ps
module power_delay_timer #(
    parameter int RISE_CYCLES = 10000,
    parameter int FALL_CYCLES = 10000,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Control
    input wire logic start_in,
    input wire logic up_in,
    output logic busy_out,
    output logic done_out
);
    logic [CNT_W-1:0] cnt;
    wire [CNT_W-1:0] load_val = up_in ? CNT_W'(RISE_CYCLES) : CNT_W'(FALL_CYCLES);

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= '0;
        end else if (start_in && cnt == '0) begin
            cnt <= load_val;
        end else if (cnt != '0) begin
            cnt <= cnt - CNT_W'(1);
        end
    end

    assign busy_out = cnt != '0;
    assign done_out = cnt == CNT_W'(1);
endmodule

// File: verif/socket_system_control_fields_bench.sv
// Register-level bench for the socket system control field bank
`timescale 1ns/1ps
module socket_system_control_fields_bench;
    import sysctl_pkg::*;
    localparam int WAIT_CYC = 5;
    localparam logic [31:0] FMASK = 32'h007F_FFE0;
    localparam logic [31:0] RST_WORD = 32'h0040_9060;
    logic mclk_in, rst_in, bus_reset_n_in, pme_enable_in;
    logic [ADDR_W-1:0] avs_address_in;
    logic avs_read_in, avs_write_in;
    logic [31:0] avs_writedata_in, avs_readdata_out;
    logic [3:0] avs_byteenable_in;
    logic [1:0] avs_response_out;
    logic avs_waitrequest_out;
    logic [SOCKETS-1:0] cardbus_present_in, card_access_in, probe_start_in, probe_done_in;
    logic power_req_in, power_up_in, stream_done_in;
    logic [SOCKETS-1:0] spare_pin_out, spare_pin_oe_out;
    ctrl_t ctrl_out;
    logic irq_out;
    int failures, checks_done;
    logic [31:0] rd;
    logic [1:0] rsp;

    socket_system_control_fields #(
        .RISE_WAIT_CYCLES(WAIT_CYC),
        .FALL_WAIT_CYCLES(WAIT_CYC)
    ) i_socket_system_control_fields (
        .mclk_in(mclk_in), .rst_in(rst_in),
        .bus_reset_n_in(bus_reset_n_in), .pme_enable_in(pme_enable_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
        .avs_response_out(avs_response_out), .avs_waitrequest_out(avs_waitrequest_out),
        .cardbus_present_in(cardbus_present_in), .card_access_in(card_access_in),
        .probe_start_in(probe_start_in), .probe_done_in(probe_done_in),
        .power_req_in(power_req_in), .power_up_in(power_up_in),
        .stream_done_in(stream_done_in), .spare_pin_out(spare_pin_out),
        .spare_pin_oe_out(spare_pin_oe_out), .ctrl_out(ctrl_out), .irq_out(irq_out)
    );

    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    task close_out;
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        checks_done++;
        if ((got & mask) !== (exp & mask)) begin
            failures++;
            $display("FAIL %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task chk_bits(input logic [5:0] got, input logic [5:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t pins got %b exp %b", $time, got, exp);
        end
    endtask

    // Request stays up until waitrequest is seen low at a rising edge; a hang is the watchdog's
    task bus_wait;
        do begin
            @(posedge mclk_in);
        end while (avs_waitrequest_out !== 1'b0);
    endtask

    task bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        avs_write_in <= 1'b1;
        bus_wait();
        avs_write_in <= 1'b0;
    endtask

    task bus_rd(input logic [11:0] a);
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_read_in <= 1'b1;
        bus_wait();
        rd = avs_readdata_out;
        rsp = avs_response_out;
        avs_read_in <= 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
        bus_rd(a);
        chk_word(rd, exp, mask);
    endtask

    // Kind: 0 access, 1 probe start, 2 probe done, 3 power request, 4 stream done
    task pulse(input int kind, input logic [1:0] v);
        @(posedge mclk_in);
        case (kind)
            0: card_access_in <= v;
            1: probe_start_in <= v;
            2: probe_done_in <= v;
            3: begin
                power_req_in <= 1'b1;
                power_up_in <= v[0];
            end
            default: stream_done_in <= 1'b1;
        endcase
        @(posedge mclk_in);
        card_access_in <= '0;
        probe_start_in <= '0;
        probe_done_in <= '0;
        power_req_in <= 1'b0;
        stream_done_in <= 1'b0;
    endtask

    task bus_reset_pulse(input logic pme);
        @(posedge mclk_in);
        pme_enable_in <= pme;
        bus_reset_n_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        bus_reset_n_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
    endtask

    // Long enough for every sequence below, with margin
    initial begin
        #3000000;
        failures++;
        close_out();
    end

    initial begin
        failures = 0;
        checks_done = 0;
        rst_in = 1'b1;
        bus_reset_n_in = 1'b1;
        pme_enable_in = 1'b0;
        avs_address_in = '0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = '0;
        avs_byteenable_in = '0;
        cardbus_present_in = '0;
        card_access_in = '0;
        probe_start_in = '0;
        probe_done_in = '0;
        power_req_in = 1'b0;
        power_up_in = 1'b0;
        stream_done_in = 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd_chk(SYSCTL_FN0_ADDR, RST_WORD, FMASK);
        chk_bits(ctrl_out, 6'b00_1011);
        cardbus_present_in <= 2'b11;
        repeat (4) @(posedge mclk_in);
        chk_bits({2'b00, spare_pin_oe_out, spare_pin_out}, 6'b00_1100);
        bus_wr(SYSCTL_FN0_ADDR, 32'hFFFF_FFFF, 4'hF);
        rd_chk(SYSCTL_FN0_ADDR, 32'h007F_D060, FMASK);
        chk_bits(ctrl_out, 6'b01_1111);
        // Function 1 may not touch the global bits
        bus_wr(SYSCTL_FN1_ADDR, 32'h0000_0000, 4'hF);
        rd_chk(SYSCTL_FN0_ADDR, 32'h0020_D060, FMASK);
        @(posedge mclk_in);
        chk_bits({4'h0, spare_pin_oe_out}, 6'h00);
        bus_wr(SYSCTL_FN0_ADDR, 32'h0000_0000, 4'b0100);
        rd_chk(SYSCTL_FN0_ADDR, 32'h0000_D060, FMASK);
        bus_wr(SYSCTL_FN0_ADDR, 32'h0000_0000, 4'b0011);
        bus_wr(SYSCTL_FN1_ADDR, 32'h0020_0000, 4'hF);
        rd_chk(SYSCTL_FN0_ADDR, 32'h0000_1000, FMASK);
        chk_bits(ctrl_out, 6'b10_0000);
        // Activity flag is sticky until read
        pulse(0, 2'b01);
        rd_chk(SYSCTL_FN0_ADDR, 32'h0000_2000, 32'h0000_2000);
        rd_chk(SYSCTL_FN0_ADDR, 32'h0000_0000, 32'h0000_2000);
        rd_chk(SYSCTL_FN1_ADDR, 32'h0000_0000, 32'h0000_2000);
        pulse(0, 2'b10);
        rd_chk(SYSCTL_FN1_ADDR, 32'h0000_2000, 32'h0000_2000);
        bus_rd(12'h300);
        chk_word({30'h0, rsp}, {30'h0, RESP_DECODE_ERR}, 32'h0000_0003);
        chk_word(rd, 32'h0000_0000, 32'hFFFF_FFFF);
        // Interrogation flags and their done events, both sockets
        pulse(1, 2'b11);
        rd_chk(SYSCTL_FN0_ADDR, 32'h0000_0100, 32'h0000_0100);
        rd_chk(SYSCTL_FN1_ADDR, 32'h0000_0100, 32'h0000_0100);
        pulse(2, 2'b11);
        rd_chk(SYSCTL_FN0_ADDR, 32'h0000_0000, 32'h0000_0100);
        rd_chk(SYSCTL_FN1_ADDR, 32'h0000_0000, 32'h0000_0100);
        rd_chk(IRQ_STATUS_ADDR, 32'h0000_0006, 32'h0000_0007);
        chk_bits({5'h0, irq_out}, 6'h00);
        bus_wr(IRQ_ENABLE_ADDR, 32'h0000_0007, 4'hF);
        @(posedge mclk_in);
        chk_bits({5'h0, irq_out}, 6'h01);
        bus_wr(IRQ_CLEAR_ADDR, 32'h0000_0006, 4'hF);
        @(posedge mclk_in);
        chk_bits({5'h0, irq_out}, 6'h00);
        // Power stream then settling delay, both directions
        for (int u = 1; u >= 0; u--) begin
            pulse(3, {1'b0, u[0]});
            rd_chk(SYSCTL_FN0_ADDR, 32'h0000_0800, 32'h0000_0E00);
            pulse(4, 2'b00);
            rd_chk(SYSCTL_FN0_ADDR, {20'h0, 1'b1, u[0], ~u[0], 9'h0}, 32'h0000_0E00);
            repeat (WAIT_CYC + 4) @(posedge mclk_in);
            rd_chk(SYSCTL_FN0_ADDR, 32'h0000_0000, 32'h0000_0E00);
            chk_bits({5'h0, irq_out}, 6'h01);
            bus_wr(IRQ_CLEAR_ADDR, 32'h0000_0001, 4'hF);
        end
        // Bus reset keeps global bits, context bits depend on PME
        bus_wr(SYSCTL_FN0_ADDR, 32'h0040_0060, 4'hF);
        pulse(1, 2'b01);
        bus_reset_pulse(1'b1);
        rd_chk(SYSCTL_FN0_ADDR, 32'h0040_1160, FMASK);
        bus_reset_pulse(1'b0);
        rd_chk(SYSCTL_FN0_ADDR, 32'h0040_1060, FMASK);
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd_chk(SYSCTL_FN0_ADDR, RST_WORD, FMASK);
        chk_bits(ctrl_out, 6'b00_1011);
        close_out();
    end
endmodule
